//--- hdl/qls_regs.sv
// Status, interrupt and control registers of a four channel line transceiver.
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps

// Notes on behaviour
// - Signal-absent status bit n follows loss detector of channel n.
// - Any rising or falling change of signal-absent status makes an event.
// - Reading the signal-absent pending register clears all its bits.
// - Driver-fault status bit n follows short monitor of channel n.
// - Driver-fault flags are masked unless fault detection is supported.
// - Reading the driver-fault pending register clears all its bits.
// - Signal-absent interrupt of channel n enabled only by enable bit n.
// - Driver-fault interrupt of channel n enabled only by enable bit n.
// - Both interrupt enable registers reset to zero.
// - Signal-absent pending bit sets on change, holds until cleared.
// - Driver-fault pending bit sets on change, holds until cleared.
// - Write to soft-init register runs 1 us reset of all registers.
// - Tap select bits 3 to 0 choose monitoring point, 7 to 4 reserved.
// - Local loop bit n enables digital loopback on channel n.
// - Loss detection and all-ones stay active during loopback.
// - Loopback routes transmit data and clock to receive outputs.
// - Status and local loop registers reset to zero.
// - All-ones transmission sends continuous marks on line outputs.
module qls_regs (
    input  wire logic                                core_clk_in,        // System clock.
    input  wire logic                                reset_n_in,         // Async reset.
    input  wire qls_pkg::qls_bus_t                   bus_in,             // Host access.
    output logic [7:0]                               rdata_out,          // Read data.
    input  wire logic [qls_pkg::CHANNELS-1:0]        loss_detect_in,     // Loss detectors.
    input  wire logic [qls_pkg::CHANNELS-1:0]        short_detect_in,    // Short monitors.
    input  wire logic                                fault_supported_in, // T1 at 3.3 V.
    input  wire logic [qls_pkg::CHANNELS-1:0]        all_ones_transmit_in, // All-ones req.
    input  wire qls_pkg::qls_line_t [qls_pkg::CHANNELS-1:0] tx_line_in,  // Tx system side.
    input  wire qls_pkg::qls_line_t [qls_pkg::CHANNELS-1:0] rx_recov_in, // Recovered rx.
    output qls_pkg::qls_line_t [qls_pkg::CHANNELS-1:0] rx_line_out,      // Rx system side.
    output logic [qls_pkg::CHANNELS-1:0]             line_mark_out,      // Line marks forced.
    output logic [3:0]                               tap_select_code_out, // Monitor select.
    output logic                                     soft_init_busy_out, // Soft init running.
    output logic                                     irq_out             // Interrupt.
);
    import qls_pkg::*;

    logic [CHANNELS-1:0] loss_s1_q, loss_s2_q, loss_s3_q;
    logic [CHANNELS-1:0] shrt_s1_q, shrt_s2_q, shrt_s3_q;
    logic [CHANNELS-1:0] signal_absent_flags_q;
    logic [CHANNELS-1:0] driver_fault_flags_q;
    logic [CHANNELS-1:0] signal_absent_flags_d;
    logic [CHANNELS-1:0] driver_fault_flags_d;
    logic [7:0]          sig_irq_en_q;
    logic [7:0]          flt_irq_en_q;
    logic [CHANNELS-1:0] sig_pending_q;
    logic [CHANNELS-1:0] flt_pending_q;
    logic [7:0]          tap_point_q;
    logic [CHANNELS-1:0] local_loop_q;
    logic [INIT_CNT_W-1:0] init_cnt_q;
    logic                soft_init;
    logic                sig_clear;
    logic                flt_clear;
    logic [CHANNELS-1:0] sig_change;
    logic [CHANNELS-1:0] flt_change;

    function automatic logic [7:0] widen(input logic [CHANNELS-1:0] v);
        widen = {4'h0, v};
    endfunction

    // Detector inputs come from the analog side; accept a change when stages agree.
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            loss_s1_q <= CHAN_RESET;
            loss_s2_q <= CHAN_RESET;
            loss_s3_q <= CHAN_RESET;
            shrt_s1_q <= CHAN_RESET;
            shrt_s2_q <= CHAN_RESET;
            shrt_s3_q <= CHAN_RESET;
        end else begin
            loss_s1_q <= loss_detect_in;
            loss_s2_q <= loss_s1_q;
            loss_s3_q <= loss_s2_q;
            shrt_s1_q <= short_detect_in;
            shrt_s2_q <= shrt_s1_q;
            shrt_s3_q <= shrt_s2_q;
        end
    end

    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            signal_absent_flags_d[i] = (loss_s2_q[i] == loss_s3_q[i]) ? loss_s3_q[i]
                                       : signal_absent_flags_q[i];
            driver_fault_flags_d[i]  = (shrt_s2_q[i] == shrt_s3_q[i])
                                       ? (shrt_s3_q[i] & fault_supported_in)
                                       : driver_fault_flags_q[i];
        end
    end

    assign soft_init  = bus_in.wr && (bus_in.addr == ADDR_SOFT_INIT);
    assign sig_clear  = bus_in.rd && (bus_in.addr == ADDR_SIG_PENDING);
    assign flt_clear  = bus_in.rd && (bus_in.addr == ADDR_FLT_PENDING);
    assign sig_change = signal_absent_flags_d ^ signal_absent_flags_q;
    assign flt_change = driver_fault_flags_d ^ driver_fault_flags_q;

    // Soft init holds every register at its default for the whole busy time.
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            init_cnt_q <= '0;
        end else if (soft_init) begin
            init_cnt_q <= INIT_CNT_W'(SOFT_INIT_CYCLES);
        end else if (init_cnt_q != '0) begin
            init_cnt_q <= init_cnt_q - INIT_CNT_W'(1);
        end
    end

    assign soft_init_busy_out = (init_cnt_q != '0);

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            signal_absent_flags_q <= CHAN_RESET;
            driver_fault_flags_q  <= CHAN_RESET;
        end else if (soft_init || soft_init_busy_out) begin
            signal_absent_flags_q <= CHAN_RESET;
            driver_fault_flags_q  <= CHAN_RESET;
        end else begin
            signal_absent_flags_q <= signal_absent_flags_d;
            driver_fault_flags_q  <= driver_fault_flags_d;
        end
    end

    // A change in the clearing cycle survives: set wins over clear.
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sig_pending_q <= CHAN_RESET;
        end else if (soft_init || soft_init_busy_out) begin
            sig_pending_q <= CHAN_RESET;
        end else begin
            sig_pending_q <= (sig_clear ? CHAN_RESET : sig_pending_q) | sig_change;
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            flt_pending_q <= CHAN_RESET;
        end else if (soft_init || soft_init_busy_out) begin
            flt_pending_q <= CHAN_RESET;
        end else begin
            flt_pending_q <= (flt_clear ? CHAN_RESET : flt_pending_q) | flt_change;
        end
    end

    // Upper enable bits are stored as written; the host keeps them zero.
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sig_irq_en_q <= REG_RESET;
            flt_irq_en_q <= REG_RESET;
            tap_point_q  <= REG_RESET;
            local_loop_q <= CHAN_RESET;
        end else if (soft_init || soft_init_busy_out) begin
            sig_irq_en_q <= REG_RESET;
            flt_irq_en_q <= REG_RESET;
            tap_point_q  <= REG_RESET;
            local_loop_q <= CHAN_RESET;
        end else if (bus_in.wr) begin
            case (bus_in.addr)
                ADDR_SIG_IRQ_EN: begin
                    sig_irq_en_q <= bus_in.wdata;
                end
                ADDR_FLT_IRQ_EN: begin
                    flt_irq_en_q <= bus_in.wdata;
                end
                ADDR_TAP_SELECT: begin
                    tap_point_q <= bus_in.wdata;
                end
                ADDR_LOCAL_LOOP: begin
                    local_loop_q <= bus_in.wdata[FIELD_MSB:FIELD_LSB];
                end
                default: begin
                end
            endcase
        end
    end

    assign tap_select_code_out = tap_point_q[FIELD_MSB:FIELD_LSB];

    // Read data stands in the cycle after the strobe.
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_out <= REG_RESET;
        end else if (bus_in.rd) begin
            case (bus_in.addr)
                ADDR_SIG_STATUS: begin
                    rdata_out <= widen(signal_absent_flags_q);
                end
                ADDR_FLT_STATUS: begin
                    rdata_out <= widen(driver_fault_flags_q);
                end
                ADDR_SIG_IRQ_EN: begin
                    rdata_out <= sig_irq_en_q;
                end
                ADDR_FLT_IRQ_EN: begin
                    rdata_out <= flt_irq_en_q;
                end
                ADDR_SIG_PENDING: begin
                    rdata_out <= widen(sig_pending_q);
                end
                ADDR_FLT_PENDING: begin
                    rdata_out <= widen(flt_pending_q);
                end
                ADDR_TAP_SELECT: begin
                    rdata_out <= {4'h0, tap_point_q[FIELD_MSB:FIELD_LSB]};
                end
                ADDR_LOCAL_LOOP: begin
                    rdata_out <= widen(local_loop_q);
                end
                default: begin
                    rdata_out <= REG_RESET;
                end
            endcase
        end else begin
            rdata_out <= REG_RESET;
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |((sig_pending_q & sig_irq_en_q[FIELD_MSB:FIELD_LSB])
                       | (flt_pending_q & flt_irq_en_q[FIELD_MSB:FIELD_LSB]));
        end
    end

    // Loopback data path; all-ones forcing stays independent of loopback.
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            rx_line_out[i]   = local_loop_q[i] ? tx_line_in[i] : rx_recov_in[i];
            line_mark_out[i] = all_ones_transmit_in[i];
        end
    end

    sig_pending_set_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (sig_change != 0 && !soft_init && !soft_init_busy_out)
        |=> ((sig_pending_q & $past(sig_change)) == $past(sig_change)))
        else $error("signal-absent change not latched");
    sig_read_clear_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (sig_clear && sig_change == 0) |=> sig_pending_q == 0)
        else $error("signal-absent pending not cleared by read");
    flt_read_clear_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (flt_clear && flt_change == 0) |=> flt_pending_q == 0)
        else $error("driver-fault pending not cleared by read");
    flt_unsupported_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (!fault_supported_in && shrt_s2_q == shrt_s3_q) |=> driver_fault_flags_q == 0)
        else $error("driver-fault flag set while unsupported");
    soft_init_len_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (soft_init && !soft_init_busy_out) |=> soft_init_busy_out [*8])
        else $error("soft init too short");
    soft_init_clear_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        soft_init |=> (local_loop_q == 0 && sig_irq_en_q == 0 && flt_irq_en_q == 0))
        else $error("soft init left registers set");
    irq_enable_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        ((sig_pending_q & sig_irq_en_q[3:0]) != 0) |=> irq_out)
        else $error("enabled pending bit gave no interrupt");
    irq_masked_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (sig_irq_en_q == 0 && flt_irq_en_q == 0) |=> !irq_out)
        else $error("interrupt raised with all enables clear");
    loop_route_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        local_loop_q[0] |-> rx_line_out[0] == tx_line_in[0])
        else $error("loopback not routed");

    // Signal-absent flags, and driver-fault flags while fault detection is supported, follow the synchroniser once its last two stages agree.
    loss_sync_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (loss_s2_q == loss_s3_q && !soft_init && !soft_init_busy_out)
        |=> signal_absent_flags_q == $past(loss_s3_q))
        else $error("signal-absent flag does not follow detector");
    loss_hold_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (loss_s2_q[0] != loss_s3_q[0] && !soft_init && !soft_init_busy_out)
        |=> signal_absent_flags_q[0] == $past(signal_absent_flags_q[0]))
        else $error("signal-absent flag moved on unsettled input");
    flt_sync_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (shrt_s2_q == shrt_s3_q && fault_supported_in && !soft_init && !soft_init_busy_out)
        |=> driver_fault_flags_q == $past(shrt_s3_q))
        else $error("driver-fault flag does not follow monitor");

    // Every change of a flag outside soft init lands in the pending register at the same edge.
    sig_event_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (!$past(soft_init) && !$past(soft_init_busy_out))
        |-> ((sig_pending_q & (signal_absent_flags_q ^ $past(signal_absent_flags_q)))
            == (signal_absent_flags_q ^ $past(signal_absent_flags_q))))
        else $error("signal-absent change gave no pending bit");
    flt_event_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (!$past(soft_init) && !$past(soft_init_busy_out))
        |-> ((flt_pending_q & (driver_fault_flags_q ^ $past(driver_fault_flags_q)))
            == (driver_fault_flags_q ^ $past(driver_fault_flags_q))))
        else $error("driver-fault change gave no pending bit");
    sig_pend_hold_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (!sig_clear && !soft_init && !soft_init_busy_out)
        |=> (sig_pending_q & $past(sig_pending_q)) == $past(sig_pending_q))
        else $error("signal-absent pending bit lost");
    flt_pend_hold_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (!flt_clear && !soft_init && !soft_init_busy_out)
        |=> (flt_pending_q & $past(flt_pending_q)) == $past(flt_pending_q))
        else $error("driver-fault pending bit lost");
    sig_no_spur_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (sig_change == 0)
        |=> (sig_pending_q & ~$past(sig_pending_q)) == 0)
        else $error("signal-absent pending set without change");
    flt_no_spur_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (flt_change == 0)
        |=> (flt_pending_q & ~$past(flt_pending_q)) == 0)
        else $error("driver-fault pending set without change");

    // Control registers take the written value one edge after the strobe.
    sig_en_write_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (bus_in.wr && bus_in.addr == ADDR_SIG_IRQ_EN && !soft_init_busy_out)
        |=> sig_irq_en_q == $past(bus_in.wdata))
        else $error("signal-absent enable write lost");
    flt_en_write_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (bus_in.wr && bus_in.addr == ADDR_FLT_IRQ_EN && !soft_init_busy_out)
        |=> flt_irq_en_q == $past(bus_in.wdata))
        else $error("driver-fault enable write lost");
    loop_write_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (bus_in.wr && bus_in.addr == ADDR_LOCAL_LOOP && !soft_init_busy_out)
        |=> local_loop_q == $past(bus_in.wdata[FIELD_MSB:FIELD_LSB]))
        else $error("local loop write lost");
    tap_write_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (bus_in.wr && bus_in.addr == ADDR_TAP_SELECT && !soft_init_busy_out)
        |=> tap_select_code_out == $past(bus_in.wdata[FIELD_MSB:FIELD_LSB]))
        else $error("tap select write lost");

    // Values seen at the first edge after reset is released.
    en_reset_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        $rose(reset_n_in)
        |-> (sig_irq_en_q == 0 && flt_irq_en_q == 0))
        else $error("enable register not cleared by reset");
    status_reset_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        $rose(reset_n_in)
        |-> (signal_absent_flags_q == 0 && local_loop_q == 0))
        else $error("status or loop register not cleared by reset");

    // Soft init keeps everything at default and then lets go.
    busy_hold_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (soft_init_busy_out && !soft_init)
        |=> (sig_pending_q == 0 && flt_pending_q == 0 && signal_absent_flags_q == 0))
        else $error("register moved during soft init");
    busy_write_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (soft_init_busy_out && bus_in.wr && bus_in.addr == ADDR_LOCAL_LOOP)
        |=> local_loop_q == 0)
        else $error("write accepted during soft init");
    busy_end_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (init_cnt_q == INIT_CNT_W'(1) && !soft_init)
        |=> !soft_init_busy_out)
        else $error("soft init did not end");

    // Read data carry the register value in the cycle after the strobe.
    rd_status_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (bus_in.rd && bus_in.addr == ADDR_SIG_STATUS)
        |=> rdata_out == {4'h0, $past(signal_absent_flags_q)})
        else $error("signal-absent status read wrong");
    rd_fault_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (bus_in.rd && bus_in.addr == ADDR_FLT_STATUS)
        |=> rdata_out == {4'h0, $past(driver_fault_flags_q)})
        else $error("driver-fault status read wrong");
    rd_tap_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (bus_in.rd && bus_in.addr == ADDR_TAP_SELECT)
        |=> rdata_out[7:4] == 4'h0)
        else $error("reserved tap bits read nonzero");
    rd_pending_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (bus_in.rd && bus_in.addr == ADDR_SIG_PENDING)
        |=> rdata_out == {4'h0, $past(sig_pending_q)})
        else $error("signal-absent pending read wrong");

    // Interrupt output follows enabled pending bits one edge later.
    irq_flt_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        ((flt_pending_q & flt_irq_en_q[FIELD_MSB:FIELD_LSB]) != 0)
        |=> irq_out)
        else $error("enabled driver-fault bit gave no interrupt");
    irq_low_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        ((sig_pending_q & sig_irq_en_q[FIELD_MSB:FIELD_LSB]) == 0
            && (flt_pending_q & flt_irq_en_q[FIELD_MSB:FIELD_LSB]) == 0)
        |=> !irq_out)
        else $error("interrupt stayed high with nothing enabled pending");

    // Line side paths.
    loop_off_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        !local_loop_q[0]
        |-> rx_line_out[0] == rx_recov_in[0])
        else $error("receive path not selected without loopback");
    loop_route3_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        local_loop_q[3]
        |-> rx_line_out[3] == tx_line_in[3])
        else $error("loopback not routed on last channel");
    loop_mark_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        local_loop_q[1]
        |-> line_mark_out[1] == all_ones_transmit_in[1])
        else $error("all-ones request lost during loopback");
endmodule

//--- shared/qls_pkg.sv
// Package holding register map, field layout and timing constants of the line status registers.
package qls_pkg;
    localparam int          CHANNELS          = 4;
    localparam logic [7:0]  ADDR_SIG_STATUS   = 8'h04;
    localparam logic [7:0]  ADDR_FLT_STATUS   = 8'h05;
    localparam logic [7:0]  ADDR_SIG_IRQ_EN   = 8'h06;
    localparam logic [7:0]  ADDR_FLT_IRQ_EN   = 8'h07;
    localparam logic [7:0]  ADDR_SIG_PENDING  = 8'h08;
    localparam logic [7:0]  ADDR_FLT_PENDING  = 8'h09;
    localparam logic [7:0]  ADDR_SOFT_INIT    = 8'h0A;
    localparam logic [7:0]  ADDR_TAP_SELECT   = 8'h0B;
    localparam logic [7:0]  ADDR_LOCAL_LOOP   = 8'h0C;
    localparam logic [7:0]  REG_RESET         = 8'h00;
    localparam logic [3:0]  CHAN_RESET        = 4'h0;
    localparam int          FIELD_LSB         = 0;
    localparam int          FIELD_MSB         = 3;
    localparam int          CLK_PERIOD_PS     = 10000;
    localparam int          SOFT_INIT_TIME_PS = 1000000;
    localparam int          SOFT_INIT_CYCLES  = SOFT_INIT_TIME_PS / CLK_PERIOD_PS;
    localparam int          INIT_CNT_W        = 8;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } qls_bus_t;

    typedef struct packed {
        logic pos;
        logic neg;
        logic clk;
    } qls_line_t;
endpackage

//--- tb/qls_host_model.sv
// Host processor model that drives the register port of the line status block.
`timescale 1ns/100ps
module qls_host_model (
    input  wire logic         core_clk_in, // System clock.
    input  wire logic [7:0]   rdata_in,    // Read data.
    input  wire logic         busy_in,     // Soft init running.
    output qls_pkg::qls_bus_t bus_out      // Host access.
);
    import qls_pkg::*;

    initial bus_out = '0;

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        while (busy_in && n < 500) begin
            @(posedge core_clk_in);
            n++;
        end
        if (a == ADDR_SIG_IRQ_EN || a == ADDR_FLT_IRQ_EN) begin
            d[7:4] = 4'h0;
        end
        @(posedge core_clk_in);
        bus_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk_in);
        bus_out <= '0;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_in);
        bus_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge core_clk_in);
        bus_out <= '0;
        #1 d = rdata_in;
    endtask
endmodule

//--- tb/tb_qls_regs.sv
// Self-checking bench for the line status and interrupt register block.
`timescale 1ns/100ps
module tb_qls_regs;
    import qls_pkg::*;
    logic                 core_clk_in = 1'b0;
    logic                 reset_n_in  = 1'b0;
    qls_bus_t             bus;
    logic [7:0]           rdata, got, sig_en, flt_en, w;
    logic [3:0]           loss = 4'h0, short_det = 4'h0, ones = 4'h0, mark, tap;
    logic                 fault_ok = 1'b1, busy, irq;
    qls_line_t [3:0]      tx_line = '0, rx_recov = '0, rx_line;
    int                   bad_count = 0, n_tests = 0, cycles = 0, n;
    logic [7:0]           reset_addrs [8] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
                                              8'h0C, 8'h1F};

    always #5 core_clk_in = ~core_clk_in;

    qls_regs dut (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .bus_in(bus),
        .rdata_out(rdata), .loss_detect_in(loss), .short_detect_in(short_det),
        .fault_supported_in(fault_ok), .all_ones_transmit_in(ones), .tx_line_in(tx_line),
        .rx_recov_in(rx_recov), .rx_line_out(rx_line), .line_mark_out(mark),
        .tap_select_code_out(tap), .soft_init_busy_out(busy), .irq_out(irq));

    qls_host_model host (.core_clk_in(core_clk_in), .rdata_in(rdata), .busy_in(busy),
        .bus_out(bus));

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 8000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [15:0] exp, input logic [15:0] act);
        n_tests++;
        if (act !== exp) begin
            bad_count++;
            $display("unexpected at %0t: expected %h got %h", $time, exp, act);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host.read_reg(a, got);
        chk(exp, got);
    endtask

    function automatic logic [11:0] exp_rx(input logic [3:0] lp, input logic [11:0] t, r);
        for (int i = 0; i < 4; i++) exp_rx[i*3 +: 3] = lp[i] ? t[i*3 +: 3] : r[i*3 +: 3];
    endfunction

    // Changes the line inputs, then checks status, pending, clear on read and interrupt.
    task automatic status_step(input logic [3:0] nl, input logic [3:0] ns, input logic nf);
        logic [3:0] ol = loss;
        logic [3:0] os = short_det & {4{fault_ok}};
        logic [3:0] es = ns & {4{nf}};
        @(posedge core_clk_in);
        loss <= nl;
        short_det <= ns;
        fault_ok <= nf;
        repeat (8) @(posedge core_clk_in);
        #1 chk((((nl ^ ol) & sig_en[3:0]) | ((es ^ os) & flt_en[3:0])) != 4'h0, irq);
        rd_chk(ADDR_SIG_STATUS, {4'h0, nl});
        rd_chk(ADDR_FLT_STATUS, {4'h0, es});
        rd_chk(ADDR_SIG_PENDING, {4'h0, nl ^ ol});
        rd_chk(ADDR_FLT_PENDING, {4'h0, es ^ os});
        rd_chk(ADDR_SIG_PENDING, 8'h00);
        rd_chk(ADDR_FLT_PENDING, 8'h00);
        repeat (2) @(posedge core_clk_in);
        #1 chk(1'b0, irq);
    endtask

    initial begin
        void'($urandom(1592));
        repeat (2) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        foreach (reset_addrs[i])
            rd_chk(reset_addrs[i], 8'h00);
        $display("test reset values done");
        sig_en = 8'($urandom()) & 8'h0F;
        flt_en = 8'($urandom()) | 8'h01;
        flt_en[7:4] = 4'h0;
        host.write_reg(ADDR_SIG_IRQ_EN, sig_en);
        host.write_reg(ADDR_FLT_IRQ_EN, flt_en);
        rd_chk(ADDR_SIG_IRQ_EN, sig_en);
        rd_chk(ADDR_FLT_IRQ_EN, flt_en);
        w = 8'($urandom());
        host.write_reg(ADDR_TAP_SELECT, w);
        rd_chk(ADDR_TAP_SELECT, {4'h0, w[3:0]});
        chk(w[3:0], tap);
        $display("test register writes done");
        for (int k = 0; k < 4; k++) begin
            w = 8'($urandom());
            host.write_reg(ADDR_LOCAL_LOOP, w);
            rd_chk(ADDR_LOCAL_LOOP, {4'h0, w[3:0]});
            @(posedge core_clk_in);
            tx_line <= 12'($urandom());
            rx_recov <= 12'($urandom());
            ones <= 4'($urandom());
            #1 chk(exp_rx(w[3:0], tx_line, rx_recov), rx_line);
            chk(ones, mark);
        end
        $display("test loopback done");
        for (int k = 0; k < 6; k++) status_step(4'($urandom()), 4'($urandom()), 1'($urandom()));
        status_step(4'hF, 4'hF, 1'b1);
        status_step(4'h0, 4'h0, 1'b1);
        $display("test status and interrupts done");
        host.write_reg(ADDR_SOFT_INIT, 8'($urandom()));
        #1 chk(1'b1, busy);
        n = 0;
        while (busy && n < 300) begin
            @(posedge core_clk_in);
            #1 n++;
        end
        chk(1'b1, n >= SOFT_INIT_CYCLES - 2 && n <= SOFT_INIT_CYCLES + 2);
        rd_chk(ADDR_SIG_IRQ_EN, 8'h00);
        rd_chk(ADDR_FLT_IRQ_EN, 8'h00);
        rd_chk(ADDR_LOCAL_LOOP, 8'h00);
        sig_en = 8'h00;
        flt_en = 8'h00;
        status_step(4'hA, 4'h5, 1'b1);
        $display("test soft init done");
        report_and_stop();
    end
endmodule
